// ===== hdl/asc_pkg.sv
// Constants and types shared by the serial control block
`default_nettype none
package asc_pkg;
  localparam logic [7:0] ADDR_CTL1 = 8'h00;
  localparam logic [7:0] ADDR_CTL2 = 8'h04;
  localparam logic [7:0] ADDR_CTL3 = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  // line_control_one fields
  localparam int C1_LOOP = 7;
  localparam int C1_ON = 6;
  localparam int C1_INV = 5;
  localparam int C1_NINE = 4;
  localparam int C1_WAKE = 3;
  localparam int C1_QSTART = 2;
  localparam int C1_PAR = 1;
  localparam int C1_ODD = 0;
  // line_control_two fields
  localparam int C2_TXE_IE = 7;
  localparam int C2_TXD_IE = 6;
  localparam int C2_RXF_IE = 5;
  localparam int C2_Q_IE = 4;
  localparam int C2_TX = 3;
  localparam int C2_RX = 2;
  localparam int C2_SBY = 1;
  localparam int C2_BRK = 0;
  // line_control_three fields
  localparam int C3_R8 = 7;
  localparam int C3_T8 = 6;
  localparam int C3_OV_IE = 3;
  localparam int C3_NS_IE = 2;
  localparam int C3_FR_IE = 1;
  localparam int C3_PA_IE = 0;
  // Status fields
  localparam int ST_TBE = 7;
  localparam int ST_DONE = 6;
  localparam int ST_RXF = 5;
  localparam int ST_QUIET = 4;
  localparam int ST_OVR = 3;
  localparam int ST_NSE = 2;
  localparam int ST_FRM = 1;
  localparam int ST_PAR = 0;
  localparam logic [7:0] C1_RST = 8'h00;
  localparam logic [7:0] C2_RST = 8'h00;
  localparam logic [7:0] C3_RST = 8'h00;
  localparam logic [7:0] C3_WMASK = 8'h4f;
  localparam logic [7:0] ST_RST = 8'hc0;
  localparam logic [7:0] RX_FLAG_MASK = 8'h3f;
  // Bit timing: sixteen clocks per serial bit
  localparam int BIT_CYCLES = 16;
  localparam logic [3:0] BIT_LAST = 4'(BIT_CYCLES - 1);
  localparam logic [3:0] BIT_MID = 4'(BIT_CYCLES / 2 - 1);
  localparam logic [3:0] LEN8 = 4'ha;
  localparam logic [3:0] LEN9 = 4'hb;
  typedef enum logic {TX_IDLE, TX_RUN} asc_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asc_rx_st_t;
endpackage
`default_nettype wire

// ===== hdl/asc_ctrl.sv
// Serial interface control logic with an APB register slave
//
// Contract
// - Loop mode feeds transmitter output to receiver, ignoring the input pin.
// - Module enable runs block; clearing sets empty and done, masks tx irq.
// - Polarity flip inverts every transmitted level, idle and break too.
// - One start, one stop; 8 or 9 data bits; 10 or 11 total.
// - Parity replaces the top data bit of the character.
// - Odd parity when select is 1, even when 0, both directions.
// - Standby exit by address mark when 1, idle line when 0.
// - Quiet ones counted after stop bit when 1, after start when 0.
// - Tx irq from empty with enable or done with enable.
// - Rx irq from buffer full with enable or quiet with enable.
// - Setting tx enable sends preamble of 10 or 11 ones.
// - Clearing tx enable finishes the current character, then idles high.
// - Toggling tx enable mid-character queues one idle character.
// - Clearing rx enable stops reception, keeps receiver flags.
// - Standby suppresses rx irqs; selected wake condition clears standby.
// - Break pulse sends one break then a 1; held sends breaks back to back.
// - Received ninth bit loads with data; bit 7 copy in 8-bit; no reset.
// - Transmit ninth bit loads with data into shifter; reset clears it.
// - Error irq from overrun with its enable; reset clears the enable.
// - Error irq from noise, framing, parity with enables; reset clears them.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`default_nettype none
module asc_ctrl
  import asc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic tx_irq,
  output logic rx_irq,
  output logic err_irq
);
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] c3;
    logic [7:0] flags;
    logic [7:0] arm;
    logic [7:0] txbuf;
    logic te_d;
    asc_tx_st_t tst;
    logic [10:0] tsh;
    logic [3:0] tcnt;
    logic [3:0] tdiv;
    logic pre_pend;
    logic brk_run;
    logic txo;
    logic [1:0] rsync;
    asc_rx_st_t rst;
    logic [3:0] rdiv;
    logic [3:0] rbit;
    logic [9:0] rsh;
    logic [1:0] smp;
    logic rnoise;
    logic [3:0] ones;
    logic idle_arm;
  } asc_state_t;

  localparam asc_state_t ST_INIT = '{
    c1: C1_RST, c2: C2_RST, c3: C3_RST, flags: ST_RST, arm: 8'h00,
    txbuf: 8'h00, te_d: 1'b0, tst: TX_IDLE, tsh: 11'h7ff, tcnt: 4'h0,
    tdiv: 4'h0, pre_pend: 1'b0, brk_run: 1'b0, txo: 1'b1, rsync: 2'h3,
    rst: RX_IDLE, rdiv: 4'h0, rbit: 4'h0, rsh: 10'h000, smp: 2'h0,
    rnoise: 1'b0, ones: 4'h0, idle_arm: 1'b0};

  asc_state_t st_reg;
  asc_state_t st_next;
  logic [7:0] rx_data_reg;
  logic rx_r8_reg;
  logic ld_rx;
  logic [8:0] rx_char;
  logic acc;
  logic mapped;
  logic on;
  logic tx_on;
  logic rx_run;
  logic sby;
  logic [3:0] flen;
  logic tx_raw;
  logic rin;

  function automatic logic [10:0] build_frame(input logic [7:0] d,
      input logic t8, input logic nine, input logic pon, input logic odd);
    logic [8:0] c;
    c = {t8, d};
    if (pon && nine) begin
      c[8] = (^d) ^ odd;
    end else if (pon) begin
      c[7] = (^d[6:0]) ^ odd;
    end
    return nine ? {1'b1, c, 1'b0} : {2'b11, c[7:0], 1'b0};
  endfunction

  assign acc = psel && penable;
  assign mapped = paddr == ADDR_CTL1 || paddr == ADDR_CTL2 ||
    paddr == ADDR_CTL3 || paddr == ADDR_STAT || paddr == ADDR_DATA;
  assign on = st_reg.c1[C1_ON];
  assign tx_on = st_reg.c2[C2_TX];
  assign rx_run = on && st_reg.c2[C2_RX];
  assign sby = st_reg.c2[C2_SBY];
  assign flen = st_reg.c1[C1_NINE] ? LEN9 : LEN8;
  assign tx_raw = (st_reg.tst == TX_RUN) ? st_reg.tsh[0] : 1'b1;
  assign rin = st_reg.c1[C1_LOOP] ? tx_raw : st_reg.rsync[1];

  always_comb begin
    logic tick;
    logic q_tick;
    logic q_val;
    logic bitv;
    logic nsy;
    logic [2:0] s3;
    logic [9:0] nsh;
    logic [8:0] pb;
    st_next = st_reg;
    tick = 1'b0;
    q_tick = 1'b0;
    q_val = 1'b0;
    bitv = 1'b0;
    nsy = 1'b0;
    s3 = 3'h0;
    nsh = st_reg.rsh;
    pb = 9'h000;
    ld_rx = 1'b0;
    rx_char = 9'h000;
    st_next.rsync = {st_reg.rsync[0], rxd_pin};
    st_next.te_d = tx_on;
    if (acc && pwrite) begin
      case (paddr)
        ADDR_CTL1: st_next.c1 = pwdata[7:0];
        ADDR_CTL2: st_next.c2 = pwdata[7:0];
        ADDR_CTL3: st_next.c3 = pwdata[7:0] & C3_WMASK;
        ADDR_DATA: begin
          st_next.txbuf = pwdata[7:0];
          st_next.flags[ST_TBE] = st_reg.flags[ST_TBE] & ~st_reg.arm[ST_TBE];
          st_next.arm[ST_TBE] = 1'b0;
        end
        default: ;
      endcase
    end
    if (acc && !pwrite && paddr == ADDR_STAT) begin
      st_next.arm = st_reg.flags;
    end
    if (acc && !pwrite && paddr == ADDR_DATA) begin
      st_next.flags = st_reg.flags & ~(st_reg.arm & RX_FLAG_MASK);
      st_next.arm = st_reg.arm & ~RX_FLAG_MASK;
    end

    // Transmitter
    if (st_reg.tst == TX_RUN) begin
      st_next.tdiv = st_reg.tdiv + 4'h1;
      tick = st_reg.tdiv == BIT_LAST;
      if (tick) begin
        st_next.tsh = {1'b1, st_reg.tsh[10:1]};
        st_next.tcnt = st_reg.tcnt - 4'h1;
      end
    end
    if (on && tx_on && !st_reg.te_d) begin
      st_next.pre_pend = 1'b1;
    end
    // Decide the next character at the last bit edge so breaks abut
    if (st_reg.tst == TX_IDLE || (tick && st_reg.tcnt == 4'h1)) begin
      st_next.tst = TX_RUN;
      st_next.tdiv = 4'h0;
      if (tx_on && st_reg.c2[C2_BRK]) begin
        st_next.tsh = 11'h000;
        st_next.tcnt = flen;
        st_next.brk_run = 1'b1;
        st_next.pre_pend = 1'b0;
      end else if (st_reg.brk_run) begin
        st_next.tsh = 11'h7ff;
        st_next.tcnt = 4'h1;
        st_next.brk_run = 1'b0;
      end else if (tx_on && st_next.pre_pend) begin
        st_next.tsh = 11'h7ff;
        st_next.tcnt = flen;
        st_next.pre_pend = 1'b0;
      end else if (tx_on && !st_reg.flags[ST_TBE]) begin
        st_next.tsh = build_frame(st_reg.txbuf, st_reg.c3[C3_T8],
          st_reg.c1[C1_NINE], st_reg.c1[C1_PAR],
          st_reg.c1[C1_ODD]);
        st_next.tcnt = flen;
        st_next.flags[ST_TBE] = 1'b1;
      end else begin
        st_next.tst = TX_IDLE;
      end
    end
    if (!on) begin
      st_next.tst = TX_IDLE;
      st_next.tsh = 11'h7ff;
      st_next.pre_pend = 1'b0;
      st_next.brk_run = 1'b0;
      st_next.flags[ST_TBE] = 1'b1;
    end
    st_next.flags[ST_DONE] = st_next.flags[ST_TBE] &&
      st_next.tst == TX_IDLE && !st_next.pre_pend && !st_next.brk_run;
    st_next.txo = ((st_next.tst == TX_RUN) ? st_next.tsh[0] : 1'b1) ^
      st_next.c1[C1_INV];

    // Receiver
    // Disabled receiver takes only the idle branch, so no flag can move
    case (rx_run ? st_reg.rst : RX_IDLE)
      RX_IDLE: begin
        st_next.rdiv = st_reg.rdiv + 4'h1;
        if (!rin) begin
          st_next.rst = RX_START;
          st_next.rdiv = 4'h0;
        end else if (st_reg.rdiv == BIT_LAST) begin
          q_tick = 1'b1;
          q_val = 1'b1;
        end
      end
      RX_START: begin
        st_next.rdiv = st_reg.rdiv + 4'h1;
        if (st_reg.rdiv == BIT_MID) begin
          st_next.rdiv = 4'h0;
          st_next.rst = rin ? RX_IDLE : RX_BITS;
          st_next.rbit = 4'h0;
          st_next.rnoise = 1'b0;
          st_next.ones = 4'h0;
        end
      end
      RX_BITS: begin
        st_next.rdiv = st_reg.rdiv + 4'h1;
        st_next.smp = {st_reg.smp[0], rin};
        if (st_reg.rdiv == BIT_LAST) begin
          // Three samples around mid bit; disagreement is noise
          s3 = {st_reg.smp, rin};
          bitv = (s3[0] & s3[1]) | (s3[0] & s3[2]) | (s3[1] & s3[2]);
          nsy = !(&s3) && |s3;
          st_next.rnoise = st_reg.rnoise | nsy;
          nsh = {bitv, st_reg.rsh[9:1]};
          st_next.rsh = nsh;
          st_next.rbit = st_reg.rbit + 4'h1;
          q_tick = !st_reg.c1[C1_QSTART];
          q_val = bitv;
          if (st_reg.rbit == flen - 4'h2) begin
            st_next.rst = RX_IDLE;
            st_next.rdiv = 4'h0;
            rx_char = st_reg.c1[C1_NINE] ? nsh[8:0] :
              {nsh[8], nsh[8:1]};
            pb = st_reg.c1[C1_NINE] ? nsh[8:0] : {1'b0, nsh[8:1]};
            if (sby && st_reg.c1[C1_WAKE] && nsh[8]) begin
              st_next.c2[C2_SBY] = 1'b0;
            end
            if (!sby || (st_reg.c1[C1_WAKE] && nsh[8])) begin
              if (st_next.flags[ST_RXF]) begin
                st_next.flags[ST_OVR] = 1'b1;
              end else begin
                ld_rx = 1'b1;
                st_next.flags[ST_RXF] = 1'b1;
                st_next.flags[ST_NSE] = st_reg.rnoise | nsy;
                st_next.flags[ST_FRM] = !nsh[9];
                st_next.flags[ST_PAR] = st_reg.c1[C1_PAR] &&
                  ((^pb) ^ st_reg.c1[C1_ODD]);
                st_next.idle_arm = 1'b1;
              end
            end
          end
        end
      end
      default: st_next.rst = RX_IDLE;
    endcase
    if (!rx_run) begin
      st_next.rst = RX_IDLE;
      st_next.rdiv = 4'h0;
      q_tick = 1'b0;
      ld_rx = 1'b0;
    end
    if (q_tick) begin
      if (!q_val) begin
        st_next.ones = 4'h0;
      end else if (st_reg.ones != flen) begin
        st_next.ones = st_reg.ones + 4'h1;
        if (st_reg.ones + 4'h1 == flen) begin
          if (sby && !st_reg.c1[C1_WAKE]) begin
            st_next.c2[C2_SBY] = 1'b0;
          end else if (st_reg.idle_arm && !sby) begin
            st_next.flags[ST_QUIET] = 1'b1;
            st_next.idle_arm = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ST_INIT;
    end else begin
      st_reg <= st_next;
    end
  end

  // Received data and ninth bit keep their value across reset
  always_ff @(posedge clk) begin
    if (ld_rx) begin
      rx_data_reg <= rx_char[7:0];
      rx_r8_reg <= rx_char[8];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      case (paddr)
        ADDR_CTL1: prdata[7:0] = st_reg.c1;
        ADDR_CTL2: prdata[7:0] = st_reg.c2;
        ADDR_CTL3: prdata[7:0] = {rx_r8_reg, st_reg.c3[6:0]};
        ADDR_STAT: prdata[7:0] = st_reg.flags;
        ADDR_DATA: prdata[7:0] = rx_data_reg;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign txd_pin = st_reg.txo;
  assign tx_irq = on && ((st_reg.flags[ST_TBE] && st_reg.c2[C2_TXE_IE]) ||
    (st_reg.flags[ST_DONE] && st_reg.c2[C2_TXD_IE]));
  assign rx_irq = !sby &&
    ((st_reg.flags[ST_RXF] && st_reg.c2[C2_RXF_IE]) ||
    (st_reg.flags[ST_QUIET] && st_reg.c2[C2_Q_IE]));
  assign err_irq = (st_reg.flags[ST_OVR] && st_reg.c3[C3_OV_IE]) ||
    (st_reg.flags[ST_NSE] && st_reg.c3[C3_NS_IE]) ||
    (st_reg.flags[ST_FRM] && st_reg.c3[C3_FR_IE]) ||
    (st_reg.flags[ST_PAR] && st_reg.c3[C3_PA_IE]);

  loop_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg.c1[C1_LOOP] && rx_run && st_reg.rst == RX_IDLE && !tx_raw)
    |=> st_reg.rst == RX_START)
    else $error("loop mode did not start reception");
  module_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !on |=> (st_reg.flags[ST_TBE] && st_reg.flags[ST_DONE] &&
    (on || !tx_irq)))
    else $error("module off did not set empty and done");
  idle_invert_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!on ##1 !on) |-> txd_pin != st_reg.c1[C1_INV])
    else $error("idle level not following polarity flip");
  tx_irq_src_a: assert property (@(posedge clk) disable iff (sys_rst)
    (on && st_reg.flags[ST_TBE] && st_reg.c2[C2_TXE_IE]) |-> tx_irq)
    else $error("empty flag with enable gave no tx irq");
  standby_mute_a: assert property (@(posedge clk) disable iff (sys_rst)
    sby |-> !rx_irq)
    else $error("rx irq raised during standby");
  overrun_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(st_reg.flags[ST_OVR]) && st_reg.c3[C3_OV_IE] |-> err_irq)
    else $error("overrun with enable gave no error irq");
  rx_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(st_reg.c2[C2_RX]) && !acc) |=>
    $stable(st_reg.flags[5:0]))
    else $error("receiver disable changed rx flags");
  tx_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg.tst == TX_IDLE && !tx_on && !st_reg.brk_run)
    |=> (st_reg.tst == TX_IDLE && txd_pin != st_reg.c1[C1_INV]))
    else $error("transmitter started while disabled");
endmodule
`default_nettype wire

// ===== testbench/asc_line_model.sv
// Far-end serial line model: sends frames on rxd, captures them from txd
`default_nettype none
module asc_line_model (
  input wire logic clk,
  input wire logic txd_pin,
  input wire logic inv,
  output var logic rxd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line rests at the mark level between frames
  initial rxd_pin = 1'b1;
  task automatic send(input logic [10:0] f, input int n);
    for (int k = 0; k < n; k++) begin
      rxd_pin <= f[k];
      repeat (16) @(posedge clk);
    end
    rxd_pin <= 1'b1;
  endtask
  task automatic hold(input logic v);
    rxd_pin <= v;
  endtask
  // Mid-bit sampling; polarity undone so frames compare in true sense
  task automatic grab(input int n, output logic [10:0] f, output int w);
    w = 0;
    while ((txd_pin ^ inv) !== 1'b0 && w < 4000) begin
      @(posedge clk);
      w++;
    end
    repeat (8) @(posedge clk);
    f = '1;
    for (int k = 0; k < n; k++) begin
      f[k] = txd_pin ^ inv;
      repeat (16) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== testbench/asc_ctrl_tb_top.sv
// Self-checking bench for the serial control block
`default_nettype none
module asc_ctrl_tb_top
  import asc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic rxd_pin, txd_pin, tx_irq, rx_irq, err_irq, inv, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  asc_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .err_irq(err_irq));
  asc_line_model i_line (.clk(clk), .txd_pin(txd_pin), .inv(inv),
    .rxd_pin(rxd_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      print_verdict();
    end
  end

  task automatic chk(input string s, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", s, exp, got);
    end
  endtask

  // Data and slave error are taken at the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Extra edge lets the written value reach the outputs before checks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    @(posedge clk);
  endtask

  task automatic rdchk(input string s, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(s, rd & m, e);
  endtask

  // Wire image of one character, LSB first, start and stop included
  function automatic logic [10:0] frame(logic [8:0] ch, logic [7:0] c1);
    logic [10:0] f;
    int nd;
    nd = c1[C1_NINE] ? 9 : 8;
    f = '1;
    f[0] = 1'b0;
    for (int k = 0; k < nd; k++) f[k + 1] = ch[k];
    if (c1[C1_PAR]) f[nd] = ^(f[9:1] & 9'((1 << (nd - 1)) - 1)) ^ c1[C1_ODD];
    return f;
  endfunction

  task automatic t_reset;
    rdchk("ctl1", ADDR_CTL1, 32'hff, C1_RST);
    rdchk("ctl2", ADDR_CTL2, 32'hff, C2_RST);
    rdchk("ctl3", ADDR_CTL3, 32'h7f, C3_RST);
    rdchk("status", ADDR_STAT, 32'hff, ST_RST);
    chk("irqs", {tx_irq, rx_irq, err_irq}, 3'b000);
    apb(1'b0, 8'h14, 8'h00);
    chk("unmapped err", last_err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    wr(ADDR_CTL3, 8'hff);
    rdchk("ctl3 ro", ADDR_CTL3, 32'h7f, C3_WMASK);
    wr(ADDR_CTL3, 8'h00);
  endtask

  task automatic t_irq;
    wr(ADDR_CTL1, 8'h40);
    wr(ADDR_CTL2, 8'h80);
    chk("tx irq empty", tx_irq, 1'b1);
    wr(ADDR_CTL2, 8'h40);
    chk("tx irq done", tx_irq, 1'b1);
    wr(ADDR_CTL2, 8'h30);
    chk("irq quiet", {tx_irq, rx_irq}, 2'b00);
    wr(ADDR_CTL2, 8'hc0);
    wr(ADDR_CTL1, 8'h00);
    chk("tx irq off", tx_irq, 1'b0);
    rdchk("flags off", ADDR_STAT, 32'hc0, 32'hc0);
    wr(ADDR_CTL1, 8'h40);
    wr(ADDR_CTL2, 8'h00);
  endtask

  task automatic t_tx;
    logic [7:0] c1 [5] = '{8'h40, 8'h50, 8'h42, 8'h53, 8'h60};
    logic [7:0] dv [5] = '{8'ha5, 8'h3c, 8'h35, 8'h96, 8'hc3};
    logic [10:0] f;
    int w, nb;
    for (int i = 0; i < 5; i++) begin
      inv = c1[i][C1_INV];
      nb = c1[i][C1_NINE] ? 11 : 10;
      wr(ADDR_CTL1, c1[i]);
      wr(ADDR_CTL3, (i == 1) ? 8'h40 : 8'h00);
      chk("idle level", txd_pin, !c1[i][C1_INV]);
      wr(ADDR_CTL2, 8'h08);
      apb(1'b0, ADDR_STAT, 8'h00);
      apb(1'b1, ADDR_DATA, dv[i]);
      i_line.grab(nb, f, w);
      chk("frame", f, frame({i == 1, dv[i]}, c1[i]));
      chk("preamble", w >= nb * 16 - 16 && w <= nb * 16 + 8, 1'b1);
      wr(ADDR_CTL2, 8'h00);
      repeat (24) @(posedge clk);
    end
    inv = 1'b0;
  endtask

  task automatic t_rx;
    logic [7:0] c1 [3] = '{8'h42, 8'h50, 8'h40};
    logic [8:0] ch [3] = '{9'h0b5, 9'h1a5, 9'h03c};
    logic [7:0] c2 [3] = '{8'h20, 8'h24, 8'h24};
    logic [7:0] st [3] = '{8'h21, 8'h20, 8'h20};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTL1, c1[i]);
      wr(ADDR_CTL3, 8'h01);
      wr(ADDR_CTL2, 8'h24);
      i_line.send(frame(ch[i], c1[i] & 8'hfc), c1[i][C1_NINE] ? 11 : 10);
      repeat (4) @(posedge clk);
      wr(ADDR_CTL2, c2[i]);
      chk("rx irq", rx_irq, 1'b1);
      chk("err irq", err_irq, i == 0);
      rdchk("rx flags", ADDR_STAT, 32'h2f, st[i]);
      rdchk("rx data", ADDR_DATA, 32'hff, ch[i][7:0]);
      rdchk("rx ninth", ADDR_CTL3, 32'h80,
        {ch[i][c1[i][C1_NINE] ? 8 : 7], 7'h0});
    end
    wr(ADDR_CTL2, 8'h14);
    chk("quiet early", rx_irq, 1'b0);
    for (int n = 0; n < 400 && rx_irq !== 1'b1; n++) @(posedge clk);
    chk("quiet irq", rx_irq, 1'b1);
  endtask

  // Far end holds a break level that must not reach the receiver
  task automatic t_loop;
    wr(ADDR_CTL1, 8'hc0);
    i_line.hold(1'b0);
    wr(ADDR_CTL2, 8'h0c);
    apb(1'b0, ADDR_STAT, 8'h00);
    apb(1'b1, ADDR_DATA, 8'h69);
    rd = 32'h0;
    for (int n = 0; n < 300 && rd[ST_RXF] !== 1'b1; n++) begin
      apb(1'b0, ADDR_STAT, 8'h00);
    end
    rdchk("loop data", ADDR_DATA, 32'hff, 32'h69);
    wr(ADDR_CTL2, 8'h00);
    i_line.hold(1'b1);
  endtask

  // Break held over two characters, then released behind a queued byte
  task automatic t_brk;
    logic [10:0] f;
    int w;
    wr(ADDR_CTL1, 8'h40);
    wr(ADDR_CTL2, 8'h08);
    // Preamble is out before break is touched
    repeat (200) @(posedge clk);
    wr(ADDR_CTL2, 8'h09);
    i_line.grab(11, f, w);
    chk("break run", f, 11'h000);
    wr(ADDR_CTL2, 8'h08);
    apb(1'b0, ADDR_STAT, 8'h00);
    apb(1'b1, ADDR_DATA, 8'ha5);
    while (txd_pin !== 1'b1) @(posedge clk);
    i_line.grab(10, f, w);
    chk("break tail", w, BIT_CYCLES);
    chk("after break", f, frame(9'h0a5, 8'h40));
    wr(ADDR_CTL2, 8'h00);
  endtask

  // Address-mark wakeup; a second unread character overruns
  task automatic t_wake;
    wr(ADDR_CTL1, 8'h48);
    wr(ADDR_CTL3, 8'h08);
    wr(ADDR_CTL2, 8'h26);
    i_line.send(frame(9'h035, 8'h40), 10);
    repeat (4) @(posedge clk);
    chk("asleep", {rx_irq, err_irq}, 2'b00);
    rdchk("still standby", ADDR_CTL2, 32'hff, 32'h26);
    i_line.send(frame(9'h0b5, 8'h40), 10);
    repeat (4) @(posedge clk);
    rdchk("woken", ADDR_CTL2, 32'hff, 32'h24);
    chk("wake irq", rx_irq, 1'b1);
    i_line.send(frame(9'h035, 8'h40), 10);
    repeat (4) @(posedge clk);
    chk("overrun irq", err_irq, 1'b1);
    rdchk("overrun", ADDR_STAT, 32'h28, 32'h28);
    rdchk("kept data", ADDR_DATA, 32'hff, 32'hb5);
    wr(ADDR_CTL2, 8'h00);
    wr(ADDR_CTL3, 8'h00);
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    inv = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_irq();
    t_tx();
    t_rx();
    t_loop();
    t_brk();
    t_wake();
    print_verdict();
  end
endmodule
`default_nettype wire
